// ==== hdlc_tx_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module hdlc_tx_model (
  input wire logic clk_in,
  input wire logic start_in,
  input wire logic [6:0] len_in,
  input wire logic [7:0] data_in,
  input wire logic [1:0] gap_in,
  input wire logic [1:0] start_ctrl_in,
  output logic [1:0] ctrl_out,
  output logic [6:0] addr_out,
  output logic done_out
);
  logic [7:0] mem [0:95];
  initial begin
    ctrl_out = 2'h3;
    addr_out = 7'h00;
    done_out = 1'b0;
    forever begin
      @(posedge clk_in);
      if (start_in) begin
        ctrl_out <= start_ctrl_in;
        for (int i = 0; i < len_in; i++) begin
          addr_out <= 7'(i);
          repeat (2 + gap_in) @(posedge clk_in);
          mem[i] = data_in;
        end
        done_out <= 1'b1;
        @(posedge clk_in);
        done_out <= 1'b0;
        ctrl_out <= 2'h3;
      end
    end
  end
endmodule : hdlc_tx_model
`default_nettype wire

// ==== lapd_buffer_pkg.sv ====
package lapd_buffer_pkg;

  localparam int unsigned MSG_BYTES = 96;
  localparam int unsigned CTRL_COUNT = 3;
  localparam int unsigned STORE_BYTES = MSG_BYTES * CTRL_COUNT;

  localparam logic [11:0] BUF_ONE_PORT_OFS = 12'h700;
  localparam logic [11:0] SELECT_OFS = 12'h11b;
  localparam logic [11:0] TX_COUNT_OFS_0 = 12'h114;
  localparam logic [11:0] TX_COUNT_OFS_1 = 12'h144;
  localparam logic [11:0] TX_COUNT_OFS_2 = 12'h154;
  localparam logic [11:0] RX_COUNT_OFS_0 = 12'h115;
  localparam logic [11:0] RX_COUNT_OFS_1 = 12'h145;
  localparam logic [11:0] RX_COUNT_OFS_2 = 12'h155;
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h120;
  localparam logic [11:0] IRQ_ENABLE_OFS = 12'h121;
  localparam logic [11:0] IRQ_CLEAR_OFS = 12'h122;

  localparam int unsigned FLAG_BIT = 7;
  localparam int unsigned IRQ_RX_LSB = 0;
  localparam int unsigned IRQ_TX_LSB = 3;

  localparam logic [1:0] NO_CTRL = 2'h3;
  localparam logic [1:0] SELECT_RESET = 2'h0;
  localparam logic [6:0] PTR_RESET = 7'h00;
  localparam logic [6:0] PTR_LAST = 7'h5f;
  localparam logic [6:0] MSG_BYTES_7 = 7'h60;
  localparam logic [6:0] LEN_RESET = 7'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] TX_FREE_RESET = 3'h7;
  localparam logic [2:0] RX_SEL_RESET = 3'h0;
  localparam logic [5:0] IRQ_RESET = 6'h00;

endpackage : lapd_buffer_pkg

// ==== lapd_buffer_port_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module lapd_buffer_port_checker (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic [11:0] ADDR_IN,
  input wire logic [7:0] WR_DATA_IN,
  input wire logic WR_STROBE_IN,
  input wire logic RD_STROBE_IN,
  input wire logic [7:0] RD_DATA_OUT,
  input wire logic IRQ_OUT,
  input wire logic HDLC_TX_DONE_IN,
  input wire logic HDLC_RX_EOT_IN,
  input wire logic HDLC_TX_START_OUT,
  input wire logic [1:0] HDLC_TX_START_CTRL_OUT,
  input wire logic [6:0] HDLC_TX_LEN_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);
  a_rd_data_idle: assert property (
    RD_DATA_OUT != 8'h00 |-> $past(RD_STROBE_IN)) else $error("read data outside slot");
  a_unmapped_zero: assert property (
    RD_STROBE_IN && ADDR_IN == 12'h7ff |=> RD_DATA_OUT == 8'h00) else $error("unmapped read");
  a_start_single: assert property (
    HDLC_TX_START_OUT |=> !HDLC_TX_START_OUT) else $error("start pulse too long");
  a_start_len: assert property (
    HDLC_TX_START_OUT |-> HDLC_TX_LEN_OUT inside {[7'h01:7'h60]} && HDLC_TX_START_CTRL_OUT != 2'h3)
    else $error("bad commit");
  a_start_cause: assert property (
    HDLC_TX_START_OUT |-> $past(WR_STROBE_IN) && {1'b0, HDLC_TX_LEN_OUT} == ($past(WR_DATA_IN) & 8'h7f))
    else $error("start without commit");
  a_len_hold: assert property (
    !HDLC_TX_START_OUT |-> $stable(HDLC_TX_LEN_OUT) && $stable(HDLC_TX_START_CTRL_OUT))
    else $error("commit info moved");
  a_irq_rise: assert property (
    $rose(IRQ_OUT) |-> $past(HDLC_RX_EOT_IN, 2) || $past(HDLC_TX_DONE_IN, 2) || $past(WR_STROBE_IN, 2))
    else $error("irq without cause");
  a_irq_fall: assert property (
    $fell(IRQ_OUT) |-> $past(WR_STROBE_IN, 2)) else $error("irq fell without write");
endmodule : lapd_buffer_port_checker
`default_nettype wire

// ==== lapd_byte_store.sv ====
`timescale 1ns/100ps
`default_nettype none

module lapd_byte_store (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wa_en_in,
  input wire logic [8:0] wa_idx_in,
  input wire logic [7:0] wa_data_in,
  input wire logic wb_en_in,
  input wire logic [8:0] wb_idx_in,
  input wire logic [7:0] wb_data_in,
  input wire logic [8:0] ra_idx_in,
  output logic [7:0] ra_data_out,
  input wire logic [8:0] rb_idx_in,
  output logic [7:0] rb_data_out
);

  logic [7:0] mem_reg [lapd_buffer_pkg::STORE_BYTES];

  // Port B carries received line data and wins a same-byte collision.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < lapd_buffer_pkg::STORE_BYTES; i++) begin
        mem_reg[i] <= lapd_buffer_pkg::BYTE_RESET;
      end
    end else begin
      if (wa_en_in && !(wb_en_in && wb_idx_in == wa_idx_in)) begin
        mem_reg[wa_idx_in] <= wa_data_in;
      end
      if (wb_en_in) begin
        mem_reg[wb_idx_in] <= wb_data_in;
      end
    end
  end

  assign ra_data_out = mem_reg[ra_idx_in];
  assign rb_data_out = mem_reg[rb_idx_in];

endmodule : lapd_byte_store

`default_nettype wire

// ==== lapd_message_buffer_port.sv ====
// Behaviour
// RULE1: 96-byte buffer behind one byte-wide port.
// RULE2: Port reaches buffer of selected controller.
// RULE3: Software checks free flag before loading.
// RULE4: Loaded message is handed to the sender.
// RULE5: Sent contents need not be kept.
// RULE6: Software checks receive flag after interrupt.
// RULE7: Repeated port reads return received message.
// RULE8: Every port access advances the byte pointer; here not with select value 3.
// RULE9: Pointer restarts per message, stops at end.
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module lapd_message_buffer_port (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic [11:0] ADDR_IN,
  input wire logic [7:0] WR_DATA_IN,
  input wire logic WR_STROBE_IN,
  input wire logic RD_STROBE_IN,
  output logic [7:0] RD_DATA_OUT,
  output logic IRQ_OUT,
  input wire logic [1:0] HDLC_TX_CTRL_IN,
  input wire logic [6:0] HDLC_TX_ADDR_IN,
  output logic [7:0] HDLC_TX_DATA_OUT,
  input wire logic HDLC_TX_DONE_IN,
  output logic HDLC_TX_START_OUT,
  output logic [1:0] HDLC_TX_START_CTRL_OUT,
  output logic [6:0] HDLC_TX_LEN_OUT,
  input wire logic [1:0] HDLC_RX_CTRL_IN,
  input wire logic HDLC_RX_WR_IN,
  input wire logic [6:0] HDLC_RX_ADDR_IN,
  input wire logic [7:0] HDLC_RX_DATA_IN,
  input wire logic HDLC_RX_EOT_IN,
  input wire logic [6:0] HDLC_RX_LEN_IN
);

  // Maps an address onto one of three per-controller offsets, or none.
  function automatic logic [1:0] match3(input logic [11:0] a, input logic [11:0] o0,
                                        input logic [11:0] o1, input logic [11:0] o2);
    logic [1:0] r;
    r = lapd_buffer_pkg::NO_CTRL;
    if (a == o0) begin
      r = 2'h0;
    end else if (a == o1) begin
      r = 2'h1;
    end else if (a == o2) begin
      r = 2'h2;
    end
    return r;
  endfunction : match3

  // Flat store index of a byte in one controller's buffer.
  function automatic logic [8:0] byte_index(input logic [1:0] ctrl, input logic [6:0] ptr);
    logic [8:0] r;
    r = 9'({ctrl, 7'h00} - {2'h0, ctrl, 5'h00}) + {2'h0, ptr};
    return r;
  endfunction : byte_index

  // Builds a count register image: flag on top, length below it.
  function automatic logic [7:0] count_byte(input logic flag, input logic [6:0] len);
    logic [7:0] r;
    r = lapd_buffer_pkg::BYTE_RESET;
    r[lapd_buffer_pkg::FLAG_BIT] = flag;
    r[6:0] = len;
    return r;
  endfunction : count_byte

  logic [1:0] select_reg;
  logic [6:0] ptr_reg;
  logic [2:0] tx_free_reg;
  logic [2:0] rx_sel_reg;
  logic [6:0] tx_len_reg [lapd_buffer_pkg::CTRL_COUNT];
  logic [6:0] rx_len_reg [lapd_buffer_pkg::CTRL_COUNT];
  logic [5:0] irq_status_reg;
  logic [5:0] irq_enable_reg;
  logic [7:0] rd_data_reg;
  logic irq_reg;
  logic [7:0] tx_data_reg;
  logic tx_start_reg;
  logic [1:0] tx_start_ctrl_reg;
  logic [6:0] tx_start_len_reg;

  logic sel_ok;
  logic port_wr;
  logic port_rd;
  logic [1:0] tx_hit;
  logic [1:0] rx_hit;
  logic sw_store_wr;
  logic commit;
  logic rx_last_read;
  logic [6:0] rx_len_sel;
  logic [7:0] sw_rd_byte;
  logic [7:0] hdlc_rd_byte;
  logic [2:0] tx_done_vec;
  logic [2:0] rx_eot_vec;
  logic [2:0] commit_vec;
  logic [2:0] rx_clr_vec;
  logic [5:0] irq_event;

  // Select value 3 parks the port on no buffer; accesses neither store nor advance.
  assign sel_ok = (select_reg != lapd_buffer_pkg::NO_CTRL);
  // RULE1: single data port
  assign port_wr = WR_STROBE_IN && (ADDR_IN == lapd_buffer_pkg::BUF_ONE_PORT_OFS);
  assign port_rd = RD_STROBE_IN && (ADDR_IN == lapd_buffer_pkg::BUF_ONE_PORT_OFS);
  assign tx_hit = match3(ADDR_IN, lapd_buffer_pkg::TX_COUNT_OFS_0,
                         lapd_buffer_pkg::TX_COUNT_OFS_1, lapd_buffer_pkg::TX_COUNT_OFS_2);
  assign rx_hit = match3(ADDR_IN, lapd_buffer_pkg::RX_COUNT_OFS_0,
                         lapd_buffer_pkg::RX_COUNT_OFS_1, lapd_buffer_pkg::RX_COUNT_OFS_2);

  // RULE3: loads only land in a free buffer
  assign sw_store_wr = port_wr && sel_ok && tx_free_reg[select_reg];

  // A length of 1 to 96 written to a free controller's count starts the send.
  assign commit = WR_STROBE_IN && (tx_hit != lapd_buffer_pkg::NO_CTRL)
                  && tx_free_reg[tx_hit] && (WR_DATA_IN[6:0] != lapd_buffer_pkg::LEN_RESET)
                  && (WR_DATA_IN[6:0] <= lapd_buffer_pkg::MSG_BYTES_7);

  // Reading the last received byte hands the buffer back to the receiver.
  assign rx_len_sel = sel_ok ? rx_len_reg[select_reg] : lapd_buffer_pkg::LEN_RESET;
  assign rx_last_read = port_rd && sel_ok && rx_sel_reg[select_reg]
                        && ((ptr_reg == 7'(rx_len_sel - 7'h01)) || (ptr_reg == lapd_buffer_pkg::PTR_LAST));

  // One-hot event vectors per controller; controller 3 stands for none.
  always_comb begin
    tx_done_vec = 3'h0;
    rx_eot_vec = 3'h0;
    commit_vec = 3'h0;
    rx_clr_vec = 3'h0;
    if (HDLC_TX_DONE_IN && HDLC_TX_CTRL_IN != lapd_buffer_pkg::NO_CTRL) begin
      tx_done_vec[HDLC_TX_CTRL_IN] = 1'b1;
    end
    if (HDLC_RX_EOT_IN && HDLC_RX_CTRL_IN != lapd_buffer_pkg::NO_CTRL) begin
      rx_eot_vec[HDLC_RX_CTRL_IN] = 1'b1;
    end
    if (commit) begin
      commit_vec[tx_hit] = 1'b1;
    end
    if (rx_last_read) begin
      rx_clr_vec[select_reg] = 1'b1;
    end
    irq_event = lapd_buffer_pkg::IRQ_RESET;
    irq_event[lapd_buffer_pkg::IRQ_RX_LSB +: 3] = rx_eot_vec;
    irq_event[lapd_buffer_pkg::IRQ_TX_LSB +: 3] = tx_done_vec;
  end

  lapd_byte_store store (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .wa_en_in(sw_store_wr),
    .wa_idx_in(byte_index(select_reg, ptr_reg)),
    .wa_data_in(WR_DATA_IN),
    .wb_en_in(HDLC_RX_WR_IN && HDLC_RX_CTRL_IN != lapd_buffer_pkg::NO_CTRL),
    .wb_idx_in(byte_index(HDLC_RX_CTRL_IN, HDLC_RX_ADDR_IN)),
    .wb_data_in(HDLC_RX_DATA_IN),
    .ra_idx_in(byte_index(select_reg, ptr_reg)),
    .ra_data_out(sw_rd_byte),
    .rb_idx_in(byte_index(HDLC_TX_CTRL_IN, HDLC_TX_ADDR_IN)),
    .rb_data_out(hdlc_rd_byte)
  );

  // RULE2: controller select
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      select_reg <= lapd_buffer_pkg::SELECT_RESET;
    end else if (WR_STROBE_IN && ADDR_IN == lapd_buffer_pkg::SELECT_OFS) begin
      select_reg <= WR_DATA_IN[1:0];
    end
  end

  // The pointer sticks at the last byte, so an overlong load only rewrites that byte.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      ptr_reg <= lapd_buffer_pkg::PTR_RESET;
    end else if (WR_STROBE_IN && ADDR_IN == lapd_buffer_pkg::SELECT_OFS) begin
      ptr_reg <= lapd_buffer_pkg::PTR_RESET;
    // RULE9: restart on count access
    end else if ((WR_STROBE_IN || RD_STROBE_IN) && sel_ok
                 && (tx_hit == select_reg || rx_hit == select_reg)) begin
      ptr_reg <= lapd_buffer_pkg::PTR_RESET;
    // RULE8: auto increment, RULE9: hold at end
    end else if ((port_wr || port_rd) && sel_ok && ptr_reg != lapd_buffer_pkg::PTR_LAST) begin
      ptr_reg <= ptr_reg + 7'h01;
    end
  end

  // RULE3: free flag, RULE5: freed after send
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      tx_free_reg <= lapd_buffer_pkg::TX_FREE_RESET;
    end else begin
      tx_free_reg <= (tx_free_reg & ~commit_vec) | tx_done_vec;
    end
  end

  // RULE6: receive flag, set wins
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      rx_sel_reg <= lapd_buffer_pkg::RX_SEL_RESET;
    end else begin
      rx_sel_reg <= (rx_sel_reg & ~rx_clr_vec) | rx_eot_vec;
    end
  end

  // Lengths latch only at a commit and at an end of transfer.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      for (int i = 0; i < lapd_buffer_pkg::CTRL_COUNT; i++) begin
        tx_len_reg[i] <= lapd_buffer_pkg::LEN_RESET;
        rx_len_reg[i] <= lapd_buffer_pkg::LEN_RESET;
      end
    end else begin
      for (int i = 0; i < lapd_buffer_pkg::CTRL_COUNT; i++) begin
        if (commit_vec[i]) begin
          tx_len_reg[i] <= WR_DATA_IN[6:0];
        end
        if (rx_eot_vec[i]) begin
          rx_len_reg[i] <= HDLC_RX_LEN_IN;
        end
      end
    end
  end

  // RULE4: hand message to sender
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      tx_start_reg <= 1'b0;
      tx_start_ctrl_reg <= lapd_buffer_pkg::SELECT_RESET;
      tx_start_len_reg <= lapd_buffer_pkg::LEN_RESET;
      tx_data_reg <= lapd_buffer_pkg::BYTE_RESET;
    end else begin
      tx_start_reg <= commit;
      if (commit) begin
        tx_start_ctrl_reg <= tx_hit;
        tx_start_len_reg <= WR_DATA_IN[6:0];
      end
      // An idle sender parks on controller 3, which has no storage behind it.
      if (HDLC_TX_CTRL_IN != lapd_buffer_pkg::NO_CTRL) begin
        tx_data_reg <= hdlc_rd_byte;
      end else begin
        tx_data_reg <= lapd_buffer_pkg::BYTE_RESET;
      end
    end
  end

  // Status bits set on events; a set in the clearing cycle survives.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      irq_status_reg <= lapd_buffer_pkg::IRQ_RESET;
      irq_enable_reg <= lapd_buffer_pkg::IRQ_RESET;
    end else begin
      irq_status_reg <= (irq_status_reg
                         & ~((WR_STROBE_IN && ADDR_IN == lapd_buffer_pkg::IRQ_CLEAR_OFS)
                             ? WR_DATA_IN[5:0] : 6'h00))
                        | irq_event;
      if (WR_STROBE_IN && ADDR_IN == lapd_buffer_pkg::IRQ_ENABLE_OFS) begin
        irq_enable_reg <= WR_DATA_IN[5:0];
      end
    end
  end

  // The level output trails the status bits by one cycle.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // RULE7: readout of the received message
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      rd_data_reg <= lapd_buffer_pkg::BYTE_RESET;
    end else if (RD_STROBE_IN) begin
      if (port_rd) begin
        rd_data_reg <= sel_ok ? sw_rd_byte : lapd_buffer_pkg::BYTE_RESET;
      end else if (tx_hit != lapd_buffer_pkg::NO_CTRL) begin
        rd_data_reg <= count_byte(tx_free_reg[tx_hit], tx_len_reg[tx_hit]);
      end else if (rx_hit != lapd_buffer_pkg::NO_CTRL) begin
        rd_data_reg <= count_byte(rx_sel_reg[rx_hit], rx_len_reg[rx_hit]);
      end else if (ADDR_IN == lapd_buffer_pkg::SELECT_OFS) begin
        rd_data_reg <= {6'h00, select_reg};
      end else if (ADDR_IN == lapd_buffer_pkg::IRQ_STATUS_OFS) begin
        rd_data_reg <= {2'h0, irq_status_reg};
      end else if (ADDR_IN == lapd_buffer_pkg::IRQ_ENABLE_OFS) begin
        rd_data_reg <= {2'h0, irq_enable_reg};
      end else begin
        rd_data_reg <= lapd_buffer_pkg::BYTE_RESET;
      end
    end else begin
      rd_data_reg <= lapd_buffer_pkg::BYTE_RESET;
    end
  end

  assign RD_DATA_OUT = rd_data_reg;
  assign IRQ_OUT = irq_reg;
  assign HDLC_TX_DATA_OUT = tx_data_reg;
  assign HDLC_TX_START_OUT = tx_start_reg;
  assign HDLC_TX_START_CTRL_OUT = tx_start_ctrl_reg;
  assign HDLC_TX_LEN_OUT = tx_start_len_reg;

endmodule : lapd_message_buffer_port

`default_nettype wire

// ==== lapd_message_buffer_port_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module lapd_message_buffer_port_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] a = 12'h000;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rxw = 1'b0;
  logic eot = 1'b0;
  logic [1:0] rxc = 2'h3;
  logic [6:0] rxa = 7'h00;
  logic [6:0] rxl = 7'h00;
  logic [7:0] rxd = 8'h00;
  logic [1:0] gap = 2'h0;
  logic [7:0] rdo, txd, v;
  logic irq, st, done;
  logic [1:0] stc, txc;
  logic [6:0] txl, txa;
  int num_errors = 0;
  int compares = 0;

  lapd_message_buffer_port uut (.CLK_SYS_IN(clk), .RST_IN(rst), .ADDR_IN(a), .WR_DATA_IN(wd),
    .WR_STROBE_IN(wr), .RD_STROBE_IN(rd), .RD_DATA_OUT(rdo), .IRQ_OUT(irq),
    .HDLC_TX_CTRL_IN(txc), .HDLC_TX_ADDR_IN(txa), .HDLC_TX_DATA_OUT(txd),
    .HDLC_TX_DONE_IN(done), .HDLC_TX_START_OUT(st), .HDLC_TX_START_CTRL_OUT(stc),
    .HDLC_TX_LEN_OUT(txl), .HDLC_RX_CTRL_IN(rxc), .HDLC_RX_WR_IN(rxw), .HDLC_RX_ADDR_IN(rxa),
    .HDLC_RX_DATA_IN(rxd), .HDLC_RX_EOT_IN(eot), .HDLC_RX_LEN_IN(rxl));
  hdlc_tx_model far (.clk_in(clk), .start_in(st), .len_in(txl), .data_in(txd), .gap_in(gap),
    .start_ctrl_in(stc), .ctrl_out(txc), .addr_out(txa), .done_out(done));

  initial forever #12.5 clk = ~clk;

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wrb(input logic [11:0] ad, input logic [7:0] d);
    @(posedge clk);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrb

  task automatic rdb(input logic [11:0] ad);
    @(posedge clk);
    a <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdo;
  endtask : rdb

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic t_reset;
    rdb(12'h114);
    chk("tx count", 8'h80, v);
    rdb(12'h700);
    chk("port", 8'h00, v);
    rdb(12'h7ff);
    chk("unmapped", 8'h00, v);
  endtask : t_reset

  task automatic t_tx(input int c);
    logic [11:0] o;
    o = (c == 0) ? 12'h114 : (c == 1) ? 12'h144 : 12'h154;
    gap <= 2'(c);
    wrb(12'h121, 8'h38);
    wrb(12'h11b, 8'(c));
    rdb(o);
    chk("free", 8'h80, v & 8'h80);
    for (int i = 0; i < 97; i++) wrb(12'h700, (i == 96) ? 8'hee : 8'(i + 32 * c));
    wrb(o, 8'h60);
    for (int k = 0; k < 1000 && done !== 1'b1; k++) @(posedge clk);
    chk("commit ctrl", 8'(c), {6'h00, stc});
    chk("commit len", 8'h60, {1'b0, txl});
    for (int i = 0; i < 95; i++) chk("tx byte", 8'(i + 32 * c), far.mem[i]);
    chk("last byte", 8'hee, far.mem[95]);
    tick(3);
    chk("irq", 8'h01, {7'h00, irq});
    rdb(12'h120);
    chk("status", 8'(8'h08 << c), v);
    rdb(o);
    chk("free", 8'h80, v & 8'h80);
    wrb(12'h122, 8'(8'h08 << c));
    tick(2);
    chk("irq", 8'h00, {7'h00, irq});
  endtask : t_tx

  task automatic t_refuse;
    wrb(12'h11b, 8'h00);
    wrb(12'h114, 8'h00);
    wrb(12'h114, 8'h61);
    rdb(12'h114);
    chk("refused commit", 8'he0, v);
    wrb(12'h11b, 8'h03);
    rdb(12'h11b);
    chk("select", 8'h03, v);
    wrb(12'h700, 8'h55);
    rdb(12'h700);
    chk("no buffer", 8'h00, v);
    wrb(12'h11b, 8'h01);
    rdb(12'h700);
    chk("ctrl1 byte0", 8'h20, v);
  endtask : t_refuse

  task automatic t_rx(input int c, input int n);
    logic [11:0] o;
    o = (c == 0) ? 12'h115 : (c == 1) ? 12'h145 : 12'h155;
    wrb(12'h11b, 8'(c));
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rxc <= 2'(c);
      rxw <= 1'b1;
      rxa <= 7'(i);
      rxd <= 8'(8'ha0 + i);
    end
    @(posedge clk);
    rxw <= 1'b0;
    rxl <= 7'(n);
    eot <= 1'b1;
    @(posedge clk);
    eot <= 1'b0;
    rxc <= 2'h3;
    tick(3);
    chk("irq masked", 8'h00, {7'h00, irq});
    wrb(12'h121, 8'(8'h01 << c));
    tick(2);
    chk("irq", 8'h01, {7'h00, irq});
    rdb(o);
    chk("rx count", 8'(128 + n), v);
    for (int i = 0; i < n; i++) begin
      rdb(12'h700);
      chk("rx byte", 8'(8'ha0 + i), v);
    end
    rdb(o);
    chk("rx count", 8'(n), v);
    wrb(12'h122, 8'(8'h01 << c));
    tick(2);
    chk("irq", 8'h00, {7'h00, irq});
  endtask : t_rx

  task automatic end_of_test;
    if (num_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    for (int c = 0; c < 3; c++) t_tx(c);
    t_refuse();
    t_rx(0, 5);
    t_rx(2, 96);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
endmodule : lapd_message_buffer_port_tb

bind lapd_message_buffer_port lapd_buffer_port_checker props (.CLK_SYS_IN, .RST_IN, .ADDR_IN,
  .WR_DATA_IN, .WR_STROBE_IN, .RD_STROBE_IN, .RD_DATA_OUT, .IRQ_OUT, .HDLC_TX_DONE_IN,
  .HDLC_RX_EOT_IN, .HDLC_TX_START_OUT, .HDLC_TX_START_CTRL_OUT, .HDLC_TX_LEN_OUT);
`default_nettype wire
